// >>> core/cgb_pkg.sv
package cgb_pkg;
  // register offsets (byte addresses, word aligned)
  localparam logic [7:0] FIFO_CTRL_OFS   = 8'h00;
  localparam logic [7:0] FIFO_STAT_OFS   = 8'h04;
  localparam logic [7:0] QUEUE_CTRL_OFS  = 8'h08;
  localparam logic [7:0] QUEUE_STAT_OFS  = 8'h0c;
  localparam logic [7:0] GERR_CTRL_OFS   = 8'h10;
  localparam logic [7:0] GERR_STAT_OFS   = 8'h14;
  // fifo control fields
  localparam int FC_EN       = 0;
  localparam int FC_IRQ_MODE = 1;
  localparam int FC_RX_IE    = 2;
  localparam int FC_TX_IE    = 3;
  localparam int FC_FULL_IE  = 4;
  localparam int FC_OFRX_IE  = 5;
  localparam int FC_OFTX_IE  = 6;
  localparam int FC_THR_LSB  = 8;
  localparam int FC_DEPTH_LSB = 12;
  // fifo status fields
  localparam int FS_EMPTY    = 0;
  localparam int FS_FULL     = 1;
  localparam int FS_RX_FLAG  = 2;
  localparam int FS_TX_FLAG  = 3;
  localparam int FS_FULL_FLAG = 4;
  localparam int FS_OFRX_FLAG = 5;
  localparam int FS_OFTX_FLAG = 6;
  localparam int FS_LOST     = 7;
  localparam int FS_CNT_LSB  = 8;
  // queue control fields
  localparam int QC_EN       = 0;
  localparam int QC_GW_EN    = 1;
  localparam int QC_IRQ_MODE = 2;
  localparam int QC_TX_IE    = 3;
  localparam int QC_ROUTE_IE = 4;
  localparam int QC_DEPTH_LSB = 8;
  // queue status fields
  localparam int QS_EMPTY    = 0;
  localparam int QS_FULL     = 1;
  localparam int QS_TX_FLAG  = 2;
  localparam int QS_ROUTE_FLAG = 3;
  localparam int QS_LOST     = 4;
  localparam int QS_CNT_LSB  = 8;
  // global error enables and other-source flags
  localparam int GE_HIST   = 0;
  localparam int GE_DLC    = 1;
  localparam int GE_PAYLD  = 2;
  localparam int GE_QOVW   = 3;
  localparam int GE_QLOST  = 4;
  localparam int GE_GWOVW  = 5;
  localparam int GE_FLOST  = 6;
  // sizes
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW    = 4;
  localparam int QUEUE_DEPTH = 8;
  localparam int QUEUE_AW   = 3;
  localparam int ID_W       = 29;
  localparam int MSG_W      = 64;
  localparam logic [2:0] DEPTH_FOUR = 3'h1;
  localparam logic [31:0] FIFO_CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] QUEUE_CTRL_RST = 32'h0000_0000;
  typedef enum logic [1:0] {CGB_TX_IDLE, CGB_TX_FIFO, CGB_TX_QUEUE} cgb_tx_t;
endpackage

// >>> core/cgb_mem.sv
`timescale 1ns/100ps
module cgb_mem #(
  parameter int AW = 4,
  parameter int DW = 64
) (
  // clock
  input  wire logic          clk,
  // write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  // read port
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    rdata <= mem[raddr];
  end
endmodule

// >>> core/cgb_gateway.sv
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/100ps
// How it works
// - mode 1 every frame; code 000 at 1/8
// - codes 001-110 two..seven eighths; 111 full
// - full interrupt when fifo becomes full
// - disabling never clears pending interrupt flags
// - one-frame receive interrupt per stored frame
// - fifo transmit interrupt on mode condition
// - mode 1 each frame, 0 on empty
// - one-frame transmit interrupt per sent frame
// - lost fifo frame raises global error
// - global error ors all enabled sources
// - gateway queue stores routed frames, sends automatically
// - queue sends highest priority identifier first
// - full queue drops frame, sets lost flag
// - queue disable drops all, stores nothing
// - empty at most two cycles after disable, not awaiting transmit outcome
// - routing interrupt per frame accepted by queue
// - queue transmit interrupt on mode condition
// - mode 0 on empty, 1 each frame
// - routing and retransmit need no software
// - fifo sends in storage order, head only
module cgb_gateway (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // routed frames from the receive rule
  input  wire logic        route_valid,
  input  wire logic        rule_dest_pointer,
  input  wire logic [28:0] route_id,
  input  wire logic [63:0] route_data,
  // other global error sources (one-cycle events)
  input  wire logic [5:0]  gerr_src_evt,
  // transmitter
  output logic             tx_req,
  output logic      [28:0] tx_id,
  output logic      [63:0] tx_data,
  input  wire logic        tx_start,
  input  wire logic        tx_done,
  input  wire logic        tx_abort,
  // interrupt lines
  output logic             fifo_rx_irq,
  output logic             fifo_full_irq,
  output logic             fifo_ofrx_irq,
  output logic             fifo_tx_irq,
  output logic             fifo_oftx_irq,
  output logic             queue_tx_irq,
  output logic             queue_route_irq,
  output logic             global_err_irq
);
  localparam int ID_W_C = cgb_pkg::ID_W;
  localparam int FD = cgb_pkg::FIFO_DEPTH;
  localparam int FAW = cgb_pkg::FIFO_AW;
  localparam int QD = cgb_pkg::QUEUE_DEPTH;
  localparam int QAW = cgb_pkg::QUEUE_AW;

  // threshold level in entries for a depth; code 111 means full
  function automatic logic [FAW:0] thr_level(input logic [2:0] code,
                                             input logic [FAW:0] depth);
    logic [FAW+3:0] p;
    p = ({3'h0, depth} * ({1'b0, code} + 4'h1)) >> 3;
    thr_level = (p[FAW:0] == '0) ? {{FAW{1'b0}}, 1'b1} : p[FAW:0];
  endfunction

  function automatic logic wsel(input logic [7:0] ofs);
    wsel = reg_wr && (reg_addr == ofs);
  endfunction

  // control registers
  logic [31:0] fctl_q, qctl_q;
  logic [6:0]  gerr_en_q;
  wire logic       f_en     = fctl_q[cgb_pkg::FC_EN];
  wire logic       f_mode   = fctl_q[cgb_pkg::FC_IRQ_MODE];
  wire logic [2:0] rx_threshold_select = fctl_q[cgb_pkg::FC_THR_LSB +: 3];
  wire logic [2:0] fifo_depth_select = fctl_q[cgb_pkg::FC_DEPTH_LSB +: 3];
  wire logic       q_en     = qctl_q[cgb_pkg::QC_EN];
  wire logic       queue_gateway_en = qctl_q[cgb_pkg::QC_GW_EN];
  wire logic       q_mode   = qctl_q[cgb_pkg::QC_IRQ_MODE];
  wire logic [3:0] q_depth  = qctl_q[cgb_pkg::QC_DEPTH_LSB +: 4];

  always_ff @(posedge clk) begin
    if (rst) begin
      fctl_q    <= cgb_pkg::FIFO_CTRL_RST;
      qctl_q    <= cgb_pkg::QUEUE_CTRL_RST;
      gerr_en_q <= 7'h00;
    end else begin
      if (wsel(cgb_pkg::FIFO_CTRL_OFS)) fctl_q <= reg_wdata;
      if (wsel(cgb_pkg::QUEUE_CTRL_OFS)) qctl_q <= reg_wdata;
      if (wsel(cgb_pkg::GERR_CTRL_OFS)) gerr_en_q <= reg_wdata[6:0];
    end
  end

  // effective fifo depth: select 000..100 -> 2^(select+1), capped at 16
  logic [FAW:0] f_depth;
  always_comb begin
    unique case (fifo_depth_select)
      3'h0: f_depth = 5'h02;
      cgb_pkg::DEPTH_FOUR: f_depth = 5'h04;
      3'h2: f_depth = 5'h08;
      default: f_depth = 5'h10;
    endcase
  end

  // ---------------- fifo (storage order) ----------------
  logic [FAW-1:0] f_wp_q, f_rp_q;
  logic [FAW:0]   f_cnt_q;
  logic           f_abort_q;
  wire logic f_full  = (f_cnt_q == f_depth);
  wire logic f_empty = (f_cnt_q == '0);
  wire logic f_route = route_valid && !rule_dest_pointer;
  wire logic f_push  = f_route && f_en && !f_full;
  wire logic f_lost  = f_route && f_en && f_full;
  cgb_pkg::cgb_tx_t tx_src_q;
  wire logic f_txdone = tx_done && (tx_src_q == cgb_pkg::CGB_TX_FIFO);
  wire logic q_txdone = tx_done && (tx_src_q == cgb_pkg::CGB_TX_QUEUE);
  wire logic busy     = (tx_src_q != cgb_pkg::CGB_TX_IDLE);
  wire logic tx_end   = tx_done || tx_abort;
  localparam int MSG_W_C = cgb_pkg::MSG_W;
  logic [MSG_W_C-1:0] f_rdata;

  cgb_mem #(.AW(FAW), .DW(MSG_W_C)) u_fifo_mem (
    .clk   (clk),
    .we    (f_push),
    .waddr (f_wp_q),
    .wdata ({route_data}),
    .raddr (f_rp_q),
    .rdata (f_rdata)
  );

  // fifo id sidecar kept small in flops
  logic [ID_W_C-1:0] f_id_q [FD];

  always_ff @(posedge clk) begin
    if (f_push) f_id_q[f_wp_q] <= route_id;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      f_wp_q <= '0;
      f_rp_q <= '0;
      f_cnt_q <= '0;
      f_abort_q <= 1'b0;
    end else if (!f_en && (f_abort_q || !(busy &&
                 tx_src_q == cgb_pkg::CGB_TX_FIFO) || tx_end)) begin
      f_wp_q <= '0;
      f_rp_q <= '0;
      f_cnt_q <= '0;
      f_abort_q <= 1'b0;
    end else begin
      if (!f_en) f_abort_q <= 1'b1;
      if (f_push) f_wp_q <= f_wp_q + 1'b1;
      if (f_txdone) f_rp_q <= f_rp_q + 1'b1;
      f_cnt_q <= f_cnt_q + {{FAW{1'b0}}, f_push}
                 - {{FAW{1'b0}}, f_txdone};
    end
  end

  // ---------------- queue (id priority) ----------------
  logic [QD-1:0]     q_vld_q;
  logic [ID_W_C-1:0] q_id_q [QD];
  logic [63:0]       q_dat_q [QD];
  logic [QAW-1:0]    q_sel_q;
  logic [QAW:0]      q_cnt;
  logic [QAW-1:0]    q_free, q_best;
  logic              q_best_v;

  always_comb begin
    q_cnt = '0;
    q_free = '0;
    q_best = '0;
    q_best_v = 1'b0;
    for (int i = QD - 1; i >= 0; i--) begin
      if (!q_vld_q[i]) q_free = QAW'(i);
    end
    for (int i = 0; i < QD; i++) begin
      q_cnt = q_cnt + {{QAW{1'b0}}, q_vld_q[i]};
      if (q_vld_q[i] && (!q_best_v || q_id_q[i] < q_id_q[q_best])) begin
        q_best = QAW'(i);
        q_best_v = 1'b1;
      end
    end
  end

  wire logic [QAW:0] q_lim = (q_depth > 4'(QD) || q_depth == '0)
                             ? (QAW+1)'(QD) : q_depth[QAW:0];
  wire logic q_full  = (q_cnt >= q_lim);
  wire logic q_empty = (q_cnt == '0);
  wire logic q_route = route_valid && rule_dest_pointer && q_en
                       && queue_gateway_en;
  wire logic q_push  = q_route && !q_full;
  wire logic q_lost  = q_route && q_full;
  logic q_abort_q;

  always_ff @(posedge clk) begin
    if (q_push) begin
      q_id_q[q_free]  <= route_id;
      q_dat_q[q_free] <= route_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q_vld_q <= '0;
      q_abort_q <= 1'b0;
    end else if (!q_en && (q_abort_q || !(busy &&
                 tx_src_q == cgb_pkg::CGB_TX_QUEUE) || tx_end)) begin
      q_vld_q <= '0;
      q_abort_q <= 1'b0;
    end else begin
      if (!q_en) q_abort_q <= 1'b1;
      if (q_push) q_vld_q[q_free] <= 1'b1;
      if (q_txdone) q_vld_q[q_sel_q] <= 1'b0;
    end
  end

  // ---------------- transmit arbitration ----------------
  wire logic f_head_ok = f_en && !f_empty;
  wire logic q_head_ok = q_en && q_best_v;
  wire logic f_wins = f_head_ok && (!q_head_ok
                      || f_id_q[f_rp_q] <= q_id_q[q_best]);
  // source disabled now or by the write on this edge
  wire logic f_off_wr = wsel(cgb_pkg::FIFO_CTRL_OFS)
                        && !reg_wdata[cgb_pkg::FC_EN];
  wire logic q_off_wr = wsel(cgb_pkg::QUEUE_CTRL_OFS)
                        && !reg_wdata[cgb_pkg::QC_EN];
  wire logic src_off  = (tx_src_q == cgb_pkg::CGB_TX_FIFO)
                        ? (!f_en || f_off_wr) : (!q_en || q_off_wr);

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_src_q <= cgb_pkg::CGB_TX_IDLE;
      tx_req <= 1'b0;
      tx_id <= '0;
      tx_data <= '0;
      q_sel_q <= '0;
    end else begin
      unique case (tx_src_q)
        cgb_pkg::CGB_TX_IDLE: begin
          if (f_wins) begin
            tx_src_q <= cgb_pkg::CGB_TX_FIFO;
            tx_req <= 1'b1;
            tx_id <= f_id_q[f_rp_q];
          end else if (q_head_ok) begin
            tx_src_q <= cgb_pkg::CGB_TX_QUEUE;
            tx_req <= 1'b1;
            tx_id <= q_id_q[q_best];
            tx_data <= q_dat_q[q_best];
            q_sel_q <= q_best;
          end
        end
        cgb_pkg::CGB_TX_FIFO, cgb_pkg::CGB_TX_QUEUE: begin
          if (tx_src_q == cgb_pkg::CGB_TX_FIFO && tx_req && !tx_start)
            tx_data <= f_rdata;
          // pending queue request follows the best identifier
          if (tx_src_q == cgb_pkg::CGB_TX_QUEUE && tx_req && !tx_start
              && q_best_v) begin
            tx_id   <= q_id_q[q_best];
            tx_data <= q_dat_q[q_best];
            q_sel_q <= q_best;
          end
          if (tx_start) tx_req <= 1'b0;
          // unstarted request withdrawn when its source is disabled
          if (tx_end || (tx_req && !tx_start && src_off)) begin
            tx_src_q <= cgb_pkg::CGB_TX_IDLE;
            tx_req <= 1'b0;
          end
        end
      endcase
    end
  end

  // ---------------- sticky interrupt flags ----------------
  logic [5:0] fflg_q; // rx, tx, full, ofrx, oftx, lost
  logic [2:0] qflg_q; // tx, route, lost
  logic [5:0] oflg_q;
  wire logic [FAW:0] f_cnt_nx = f_cnt_q + 5'h01;
  wire logic f_thr_hit = f_push && (f_mode ? 1'b1
                   : (rx_threshold_select == 3'h7) ? (f_cnt_nx == f_depth)
                   : (f_cnt_nx == thr_level(rx_threshold_select,
                                            f_depth)));
  wire logic f_tx_ev = f_txdone && (f_mode || f_cnt_q == 5'h01);
  wire logic q_tx_ev = q_txdone && (q_mode || q_cnt == 4'h1);
  wire logic f_full_ev = f_push && (f_cnt_nx == f_depth);
  // oftx per sent frame, ofrx per stored frame
  wire logic [5:0] f_set = {f_lost, f_txdone, f_push,
                            f_full_ev, f_tx_ev, f_thr_hit};
  wire logic [2:0] q_set = {q_lost, q_push, q_tx_ev};
  wire logic [31:0] clr = reg_wdata;

  // write of zero clears, set wins over clear; enable off keeps flag
  always_ff @(posedge clk) begin
    if (rst) begin
      fflg_q <= '0;
      qflg_q <= '0;
      oflg_q <= '0;
    end else begin
      fflg_q <= f_set | (fflg_q & (wsel(cgb_pkg::FIFO_STAT_OFS)
                ? clr[7:2] : 6'h3f));
      qflg_q <= q_set | (qflg_q & (wsel(cgb_pkg::QUEUE_STAT_OFS)
                ? clr[4:2] : 3'h7));
      oflg_q <= gerr_src_evt | (oflg_q & (wsel(cgb_pkg::GERR_STAT_OFS)
                ? clr[5:0] : 6'h3f));
    end
  end

  // interrupt lines: flag and enable
  assign fifo_rx_irq     = fflg_q[0] & fctl_q[cgb_pkg::FC_RX_IE];
  assign fifo_tx_irq     = fflg_q[1] & fctl_q[cgb_pkg::FC_TX_IE];
  assign fifo_full_irq   = fflg_q[2] & fctl_q[cgb_pkg::FC_FULL_IE];
  assign fifo_ofrx_irq   = fflg_q[3] & fctl_q[cgb_pkg::FC_OFRX_IE];
  assign fifo_oftx_irq   = fflg_q[4] & fctl_q[cgb_pkg::FC_OFTX_IE];
  assign queue_tx_irq    = qflg_q[0] & qctl_q[cgb_pkg::QC_TX_IE];
  assign queue_route_irq = qflg_q[1]
                           & qctl_q[cgb_pkg::QC_ROUTE_IE];
  assign global_err_irq  = (|(oflg_q & gerr_en_q[5:0]))
                           | (qflg_q[2] & gerr_en_q[cgb_pkg::GE_QLOST])
                           | (fflg_q[5]
                              & gerr_en_q[cgb_pkg::GE_FLOST]);

  // read data stand in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        cgb_pkg::FIFO_CTRL_OFS: begin
          reg_rdata <= fctl_q;
        end
        cgb_pkg::FIFO_STAT_OFS: begin
          reg_rdata <= {19'h0, f_cnt_q, fflg_q, f_full, f_empty};
        end
        cgb_pkg::QUEUE_CTRL_OFS: begin
          reg_rdata <= qctl_q;
        end
        cgb_pkg::QUEUE_STAT_OFS: begin
          reg_rdata <= {20'h0, q_cnt, 3'h0, qflg_q, q_full, q_empty};
        end
        cgb_pkg::GERR_CTRL_OFS: begin
          reg_rdata <= {25'h0, gerr_en_q};
        end
        cgb_pkg::GERR_STAT_OFS: begin
          reg_rdata <= {26'h0, oflg_q};
        end
        default: begin
          reg_rdata <= '0;
        end
      endcase
    end
  end
endmodule

// >>> bench/cgb_can_node.sv
`timescale 1ns/100ps
module cgb_can_node (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // bench control: stall the bus
  input  wire logic        hold,
  // transmitter side of the gateway
  input  wire logic        tx_req,
  input  wire logic [28:0] tx_id,
  output logic             tx_start,
  output logic             tx_done,
  output logic             tx_abort,
  // last identifier taken off the bus
  output logic      [28:0] last_id
);
  int cnt;

  assign tx_abort = 1'b0;

  // frame takes eight cycles, then a gap so a stale request is not restarted
  always_ff @(posedge clk) begin
    tx_start <= 1'b0;
    tx_done  <= 1'b0;
    if (rst) begin
      cnt <= 0;
    end else if (cnt == 0) begin
      if (tx_req && !hold) begin
        tx_start <= 1'b1;
        last_id  <= tx_id;
        cnt      <= 1;
      end
    end else begin
      tx_done <= (cnt == 8);
      cnt     <= (cnt == 10) ? 0 : cnt + 1;
    end
  end
endmodule

// >>> bench/cgb_gateway_assertions.sv
`timescale 1ns/100ps
module cgb_gateway_assertions (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  // transmitter
  input wire logic        tx_req,
  input wire logic        tx_start,
  // interrupt lines
  input wire logic        fifo_rx_irq,
  input wire logic        fifo_full_irq,
  input wire logic        fifo_ofrx_irq,
  input wire logic        fifo_tx_irq,
  input wire logic        queue_tx_irq,
  input wire logic        queue_route_irq,
  input wire logic        global_err_irq
);
  logic [31:0] fc_q;
  logic [31:0] qc_q;
  logic [31:0] gc_q;

  // shadow of the enable registers
  always_ff @(posedge clk) begin
    if (rst) begin
      fc_q <= cgb_pkg::FIFO_CTRL_RST;
      qc_q <= cgb_pkg::QUEUE_CTRL_RST;
      gc_q <= 32'h0;
    end else if (reg_wr) begin
      if (reg_addr == cgb_pkg::FIFO_CTRL_OFS) fc_q <= reg_wdata;
      if (reg_addr == cgb_pkg::QUEUE_CTRL_OFS) qc_q <= reg_wdata;
      if (reg_addr == cgb_pkg::GERR_CTRL_OFS) gc_q <= reg_wdata;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence tx_wait;
    tx_req && !tx_start && !reg_wr;
  endsequence

  rx_irq_en_a: assert property (fifo_rx_irq |-> fc_q[cgb_pkg::FC_RX_IE])
    else $error("fifo rx irq while disabled");
  full_irq_en_a: assert property (fifo_full_irq |-> fc_q[cgb_pkg::FC_FULL_IE])
    else $error("fifo full irq while disabled");
  ofrx_irq_en_a: assert property (fifo_ofrx_irq |-> fc_q[cgb_pkg::FC_OFRX_IE])
    else $error("one-frame rx irq while disabled");
  tx_irq_en_a: assert property (fifo_tx_irq |-> fc_q[cgb_pkg::FC_TX_IE])
    else $error("fifo tx irq while disabled");
  qtx_irq_en_a: assert property (queue_tx_irq |-> qc_q[cgb_pkg::QC_TX_IE])
    else $error("queue tx irq while disabled");
  gerr_en_a: assert property (global_err_irq |-> gc_q != 32'h0)
    else $error("global error with no source enabled");
  ofrx_sticky_a: assert property ($fell(fifo_ofrx_irq) |-> $past(reg_wr))
    else $error("one-frame rx irq dropped without write");
  route_sticky_a: assert property ($fell(queue_route_irq) |-> $past(reg_wr))
    else $error("route irq dropped without write");
  tx_hold_a: assert property (tx_wait |=> tx_req)
    else $error("transmit request withdrawn before start");
endmodule

bind cgb_gateway cgb_gateway_assertions u_chk (
  .clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .tx_req, .tx_start,
  .fifo_rx_irq, .fifo_full_irq, .fifo_ofrx_irq, .fifo_tx_irq,
  .queue_tx_irq, .queue_route_irq, .global_err_irq
);

// >>> bench/cgb_gateway_tb.sv
`timescale 1ns/100ps
module cgb_gateway_tb;
  logic        clk, rst, reg_wr, reg_rd, route_valid, rule_dest_pointer;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [28:0] route_id, tx_id, last_id;
  logic [63:0] route_data, tx_data;
  logic [5:0]  gerr_src_evt;
  logic        tx_req, tx_start, tx_done, tx_abort, hold;
  logic        fifo_rx_irq, fifo_full_irq, fifo_ofrx_irq, fifo_tx_irq;
  logic        fifo_oftx_irq, queue_tx_irq, queue_route_irq, global_err_irq;
  logic [28:0] got[$];
  int          miscompares;
  int          num_checks;

  cgb_gateway dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .route_valid, .rule_dest_pointer, .route_id, .route_data,
    .gerr_src_evt, .tx_req, .tx_id, .tx_data, .tx_start, .tx_done,
    .tx_abort, .fifo_rx_irq, .fifo_full_irq, .fifo_ofrx_irq, .fifo_tx_irq,
    .fifo_oftx_irq, .queue_tx_irq, .queue_route_irq, .global_err_irq);
  cgb_can_node node (.clk, .rst, .hold, .tx_req, .tx_id, .tx_start,
    .tx_done, .tx_abort, .last_id);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) if (tx_done) got.push_back(last_id);

  function automatic logic [31:0] bt(int n);
    return 32'h1 << n;
  endfunction

  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL %0t word %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL %0t bit %b exp %b", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic route(input logic dest, input logic [28:0] id);
    @(posedge clk);
    route_valid       <= 1'b1;
    rule_dest_pointer <= dest;
    route_id          <= id;
    route_data        <= {35'h0, id};
    @(posedge clk);
    route_valid       <= 1'b0;
  endtask

  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic waitq(input int n);
    repeat (400) if (got.size() < n) @(posedge clk);
    settle;
    chk32(got.size(), n);
  endtask

  task automatic end_sim;
    if (miscompares == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #1_000_000;
    miscompares++;
    end_sim;
  end

  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, route_valid, rule_dest_pointer} = 4'h0;
    {reg_addr, reg_wdata, route_id, route_data} = '0;
    gerr_src_evt = 6'h0;
    hold = 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(cgb_pkg::FIFO_CTRL_OFS);
    chk32(d, cgb_pkg::FIFO_CTRL_RST);
    rd(cgb_pkg::QUEUE_CTRL_OFS);
    chk32(d, cgb_pkg::QUEUE_CTRL_RST);
    rd(8'h40);
    chk32(d, 32'h0);
    // threshold codes, fifo stalled, depth never four
    wr(cgb_pkg::GERR_CTRL_OFS, bt(cgb_pkg::GE_FLOST));
    for (int c = 0; c < 8; c++) begin
      wr(cgb_pkg::FIFO_CTRL_OFS, 32'h0);
      wr(cgb_pkg::FIFO_CTRL_OFS, bt(cgb_pkg::FC_EN) | bt(cgb_pkg::FC_RX_IE)
        | bt(cgb_pkg::FC_FULL_IE) | (c << cgb_pkg::FC_THR_LSB)
        | (32'h3 << cgb_pkg::FC_DEPTH_LSB));
      wr(cgb_pkg::FIFO_STAT_OFS, 32'h0);
      repeat ((c + 1) * cgb_pkg::FIFO_DEPTH / 8 - 1) route(1'b0, 29'h10);
      settle;
      chk1(fifo_rx_irq, 1'b0);
      route(1'b0, 29'h10);
      settle;
      chk1(fifo_rx_irq, 1'b1);
      chk1(fifo_full_irq, c == 7);
    end
    route(1'b0, 29'h10);
    rd(cgb_pkg::FIFO_STAT_OFS);
    chk1(d[cgb_pkg::FS_LOST], 1'b1);
    chk1(global_err_irq, 1'b1);
    wr(cgb_pkg::FIFO_STAT_OFS, 32'h0);
    settle;
    chk1(global_err_irq, 1'b0);
    // other global error sources
    for (int s = 0; s < 6; s++) begin
      wr(cgb_pkg::GERR_CTRL_OFS, bt(s));
      @(posedge clk) gerr_src_evt <= 6'h1 << s;
      @(posedge clk) gerr_src_evt <= 6'h0;
      settle;
      chk1(global_err_irq, 1'b1);
      wr(cgb_pkg::GERR_STAT_OFS, 32'h0);
      settle;
      chk1(global_err_irq, 1'b0);
    end
    // fifo mode 1, storage order
    wr(cgb_pkg::FIFO_CTRL_OFS, 32'h0);
    d = bt(cgb_pkg::FC_IRQ_MODE) | bt(cgb_pkg::FC_RX_IE) | bt(cgb_pkg::FC_TX_IE)
      | bt(cgb_pkg::FC_OFRX_IE) | bt(cgb_pkg::FC_OFTX_IE);
    wr(cgb_pkg::FIFO_CTRL_OFS, d | bt(cgb_pkg::FC_EN));
    wr(cgb_pkg::FIFO_STAT_OFS, 32'h0);
    got.delete();
    route(1'b0, 29'h9);
    route(1'b0, 29'h2);
    hold <= 1'b0;
    waitq(2);
    chk32(got[0], 32'h9);
    chk32(got[1], 32'h2);
    chk1(fifo_rx_irq, 1'b1);
    chk1(fifo_ofrx_irq, 1'b1);
    chk1(fifo_tx_irq, 1'b1);
    chk1(fifo_oftx_irq, 1'b1);
    wr(cgb_pkg::FIFO_CTRL_OFS, d);
    settle;
    chk1(fifo_tx_irq, 1'b1);
    wr(cgb_pkg::FIFO_STAT_OFS, 32'h0);
    settle;
    chk1(fifo_tx_irq, 1'b0);
    // queue: priority order, routing and empty interrupts
    got.delete();
    hold <= 1'b1;
    wr(cgb_pkg::QUEUE_CTRL_OFS, bt(cgb_pkg::QC_EN) | bt(cgb_pkg::QC_GW_EN)
      | bt(cgb_pkg::QC_TX_IE) | bt(cgb_pkg::QC_ROUTE_IE));
    route(1'b1, 29'h3);
    route(1'b1, 29'h1);
    route(1'b1, 29'h2);
    settle;
    chk1(queue_route_irq, 1'b1);
    chk1(queue_tx_irq, 1'b0);
    hold <= 1'b0;
    waitq(3);
    for (int i = 0; i < 3; i++) chk32(got[i], i + 1);
    chk1(queue_tx_irq, 1'b1);
    // queue overflow, then disable
    wr(cgb_pkg::QUEUE_STAT_OFS, 32'h0);
    wr(cgb_pkg::GERR_CTRL_OFS, bt(cgb_pkg::GE_QLOST));
    hold <= 1'b1;
    repeat (cgb_pkg::QUEUE_DEPTH + 1) route(1'b1, 29'h7);
    rd(cgb_pkg::QUEUE_STAT_OFS);
    chk1(d[cgb_pkg::QS_LOST], 1'b1);
    chk1(global_err_irq, 1'b1);
    wr(cgb_pkg::QUEUE_CTRL_OFS, 32'h0);
    hold <= 1'b0;
    settle;
    chk1(global_err_irq, 1'b1);
    got.delete();
    repeat (30) @(posedge clk);
    route(1'b1, 29'h4);
    waitq(got.size());
    chk1(got.size() < 2, 1'b1);
    rd(cgb_pkg::QUEUE_STAT_OFS);
    chk1(d[cgb_pkg::QS_EMPTY], 1'b1);
    wr(cgb_pkg::QUEUE_STAT_OFS, 32'h0);
    settle;
    chk1(global_err_irq, 1'b0);
    end_sim;
  end
endmodule
